// ---- design/ul_defines.svh ----
`ifndef UL_DEFINES_SVH
`define UL_DEFINES_SVH

// ********************************************
// Timing of the uplink line
// ********************************************

// System clock rate in Hz (25 MHz).
`define UL_CLK_HZ 32'h017D7840
// Nominal uplink bit rate in bit/s (564.48 kbit/s).
`define UL_BIT_HZ 32'h00089D00
// Rate accumulators wrap at the clock rate.
`define UL_NCO_MOD (25'(`UL_CLK_HZ))
// Step of the half-cell accumulator: two half cells per bit.
`define UL_HALF_STEP (25'(2 * `UL_BIT_HZ))
// Step of the whole-bit accumulator.
`define UL_BIT_STEP (25'(`UL_BIT_HZ))
// Clock cycles in one half cell, rounded down (22).
`define UL_HALF_CYC (`UL_CLK_HZ / (2 * `UL_BIT_HZ))

// ********************************************
// Decoder acceptance windows, in clock cycles
// ********************************************

`define UL_BND_MIN (6'(`UL_HALF_CYC - 6))
`define UL_BND_MAX (6'(`UL_HALF_CYC + 6))
`define UL_MID_MIN (6'(2 * `UL_HALF_CYC - 8))
`define UL_MID_MAX (6'(2 * `UL_HALF_CYC + 8))

// ********************************************
// Fallback handling in bit periods; encoder word width and buffer depth
// ********************************************

// Bit periods without lock before the input is judged lost.
`define UL_LOSS_BITS 7'h40
// Length of the run of ones put in front of the fallback telegram.
`define UL_FILL_BITS 7'h64
// Length of the stored fallback telegram.
`define UL_TEL_BITS 9'h155
// Width of one word taken from the encoder's user side.
`define UL_WORD_W 8
// Depth of the encoder's word buffer.
`define UL_FIFO_DEPTH 16

`endif

// ---- design/ul_encoder_end.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ul_defines.svh"

module ul_encoder_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Uplink line
  ul_link_if.encoder link,
  // Telegram words, sent least significant bit first
  input wire logic [`UL_WORD_W-1:0] wordData,
  input wire logic wordValid,
  output logic wordReady,
  // Status
  output logic idleFill
);

  // ********************************************
  // Word buffer
  // ********************************************

  logic [`UL_WORD_W-1:0] fifoData;
  logic fifoValid;
  wire fifoPop;

  ul_fifo #(.WIDTH(`UL_WORD_W), .DEPTH(`UL_FIFO_DEPTH)) i_ul_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inData(wordData),
    .inValid(wordValid),
    .inReady(wordReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // ********************************************
  // Half-cell rate generator
  // ********************************************

  logic [24:0] nco_reg;
  wire [25:0] ncoSum;
  wire halfTick;

  // Fractional accumulator keeps the mean rate exact; edges jitter one cycle.
  assign ncoSum = {1'b0, nco_reg} + {1'b0, `UL_HALF_STEP};
  assign halfTick = (ncoSum >= {1'b0, `UL_NCO_MOD});

  // ********************************************
  // Bit serialiser and line coder
  // ********************************************

  logic level_reg;
  logic secondHalf_reg;
  logic [`UL_WORD_W-1:0] shift_reg;
  logic [3:0] bitsLeft_reg;
  logic idleFill_reg;
  wire atBoundary;
  wire haveShift;
  wire nextBit;

  // The next bit comes from the shifter, then the buffer, else a run of ones.
  assign atBoundary = halfTick && secondHalf_reg;
  assign haveShift = (bitsLeft_reg != 4'h0);
  assign fifoPop = atBoundary && !haveShift;
  assign nextBit = haveShift ? shift_reg[0] : (fifoValid ? fifoData[0] : 1'b1);

  // A mid-cell edge every cell; a boundary edge only for a one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nco_reg <= '0;
      level_reg <= 1'b0;
      secondHalf_reg <= 1'b0;
      shift_reg <= '0;
      bitsLeft_reg <= 4'h0;
      idleFill_reg <= 1'b1;
    end else begin
      nco_reg <= halfTick ? 25'(ncoSum - {1'b0, `UL_NCO_MOD}) : ncoSum[24:0];
      if (halfTick) begin
        secondHalf_reg <= !secondHalf_reg;
        if (!secondHalf_reg) begin
          level_reg <= !level_reg;
        end else begin
          level_reg <= level_reg ^ nextBit;
          if (haveShift) begin
            shift_reg <= shift_reg >> 1;
            bitsLeft_reg <= bitsLeft_reg - 4'h1;
          end else if (fifoValid) begin
            shift_reg <= fifoData >> 1;
            bitsLeft_reg <= 4'(`UL_WORD_W - 1);
          end
          idleFill_reg <= !haveShift && !fifoValid;
        end
      end
    end
  end

  // The line is sent continuously with no return path.
  assign link.lineP = level_reg;
  assign link.lineN = !level_reg;
  assign idleFill = idleFill_reg;

endmodule

`default_nettype wire

// ---- design/ul_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module ul_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Draining side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign inReady = (count_reg != (AW + 1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage is written only, never reset, to keep it a plain register array.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_reg <= pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ---- design/ul_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// Two conductors of the uplink data input, driven only by the encoder end.
interface ul_link_if;
  logic lineP;
  logic lineN;

  modport encoder (output lineP, output lineN);
  modport transponder (input lineP, input lineN);
endinterface

`default_nettype wire

// ---- design/ul_pkg.sv ----
`default_nettype none

package ul_pkg;

  // Transponder telegram source selection.
  typedef enum logic [2:0] {
    UL_ST_IDLE,
    UL_ST_ACQUIRE,
    UL_ST_LIVE,
    UL_ST_FILL,
    UL_ST_FALLBACK
  } ul_src_state_e;

endpackage

`default_nettype wire

// ---- design/ul_transponder_end.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ul_defines.svh"

module ul_transponder_end #(
  parameter logic [`UL_TEL_BITS-1:0] FALLBACK_TELEGRAM = {
    {85{4'hA}}, 1'b1}
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Uplink line
  ul_link_if.transponder link,
  // Energisation by a passing train
  input wire logic energised,
  // Bits towards the air-gap transmitter
  output logic airBit,
  output logic airStrobe,
  // Status
  output logic fallbackActive,
  output logic inputLocked
);

  // ********************************************
  // Line edge detection
  // ********************************************

  logic line_reg;
  logic linePrev_reg;
  logic linePrimed_reg;
  wire lineEdge;

  // Only changes of level are used, so swapped conductors decode alike.
  assign lineEdge = line_reg ^ linePrev_reg;

  // Both stages load the pin first, so neither idle level reads as an edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_reg <= 1'b0;
      linePrev_reg <= 1'b0;
      linePrimed_reg <= 1'b0;
    end else begin
      line_reg <= link.lineP;
      linePrev_reg <= linePrimed_reg ? line_reg : link.lineP;
      linePrimed_reg <= 1'b1;
    end
  end

  // ********************************************
  // Mid-cell lock and symbol comparison
  // ********************************************

  logic [5:0] gap_reg;
  logic locked_reg;
  logic sawBoundary_reg;
  logic firstBit_reg;
  logic decBit_reg;
  logic decStrobe_reg;
  wire inBoundary;
  wire inMid;
  wire tooLong;
  wire midEdge;
  wire badEdge;

  // Window tests on the cycles since the last edge while unlocked, since the last accepted mid-cell edge once locked.
  assign inBoundary = (gap_reg >= `UL_BND_MIN) && (gap_reg <= `UL_BND_MAX);
  assign inMid = (gap_reg >= `UL_MID_MIN) && (gap_reg <= `UL_MID_MAX);
  assign tooLong = (gap_reg > `UL_MID_MAX);
  assign midEdge = lineEdge && inMid;
  assign badEdge = lineEdge && locked_reg && !inMid && !(inBoundary && !sawBoundary_reg);

  // Timing follows the line's own edges, so no local bit rate is imposed.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_reg <= '0;
      locked_reg <= 1'b0;
      sawBoundary_reg <= 1'b0;
      firstBit_reg <= 1'b1;
      decBit_reg <= 1'b0;
      decStrobe_reg <= 1'b0;
    end else begin
      decStrobe_reg <= 1'b0;
      if (!energised) begin
        gap_reg <= '0;
        locked_reg <= 1'b0;
        sawBoundary_reg <= 1'b0;
        firstBit_reg <= 1'b1;
      end else if (!locked_reg) begin
        // Two edges a whole cell apart can only both be mid-cell edges.
        gap_reg <= lineEdge ? 6'h00 : (tooLong ? gap_reg : gap_reg + 6'h01);
        locked_reg <= midEdge;
        firstBit_reg <= 1'b1;
        sawBoundary_reg <= 1'b0;
      end else if (badEdge || (tooLong && !lineEdge)) begin
        locked_reg <= 1'b0;
        gap_reg <= '0;
        sawBoundary_reg <= 1'b0;
      end else if (midEdge) begin
        // A boundary edge means the symbol repeated, which is a one.
        decBit_reg <= sawBoundary_reg;
        decStrobe_reg <= !firstBit_reg;
        firstBit_reg <= 1'b0;
        sawBoundary_reg <= 1'b0;
        gap_reg <= '0;
      end else begin
        sawBoundary_reg <= sawBoundary_reg | lineEdge;
        gap_reg <= gap_reg + 6'h01;
      end
    end
  end

  // ********************************************
  // Local bit rate for fill and fallback
  // ********************************************

  logic [24:0] nco_reg;
  wire [25:0] ncoSum;
  wire bitTick;

  assign ncoSum = {1'b0, nco_reg} + {1'b0, `UL_BIT_STEP};
  assign bitTick = (ncoSum >= {1'b0, `UL_NCO_MOD});

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nco_reg <= '0;
    end else begin
      nco_reg <= bitTick ? 25'(ncoSum - {1'b0, `UL_NCO_MOD}) : ncoSum[24:0];
    end
  end

  // ********************************************
  // Telegram source selection
  // ********************************************

  ul_pkg::ul_src_state_e state_reg;
  ul_pkg::ul_src_state_e state_next;
  logic [6:0] lossCnt_reg;
  logic [6:0] fillCnt_reg;
  logic [8:0] telIdx_reg;
  logic airBit_reg;
  logic airStrobe_reg;
  logic fallback_reg;
  wire lossHit;
  wire fillDone;
  wire telLast;

  // Loss is judged after a fixed number of unlocked bit periods; with the fill
  // run this stays well inside the 341-bit bound.
  assign lossHit = !locked_reg && bitTick && (lossCnt_reg == `UL_LOSS_BITS - 7'h01);
  assign fillDone = bitTick && (fillCnt_reg == `UL_FILL_BITS - 7'h01);
  assign telLast = (telIdx_reg == `UL_TEL_BITS - 9'h001);

  // Next source; losing energisation always wins and clears fallback.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ul_pkg::UL_ST_IDLE: begin
        state_next = ul_pkg::UL_ST_ACQUIRE;
      end
      ul_pkg::UL_ST_ACQUIRE: begin
        if (lossHit) begin
          state_next = ul_pkg::UL_ST_FILL;
        end else if (locked_reg) begin
          state_next = ul_pkg::UL_ST_LIVE;
        end
      end
      ul_pkg::UL_ST_LIVE: begin
        if (lossHit) begin
          state_next = ul_pkg::UL_ST_FILL;
        end
      end
      ul_pkg::UL_ST_FILL: begin
        if (fillDone) begin
          state_next = ul_pkg::UL_ST_FALLBACK;
        end
      end
      default: begin
        state_next = ul_pkg::UL_ST_FALLBACK;
      end
    endcase
    if (!energised) begin
      state_next = ul_pkg::UL_ST_IDLE;
    end
  end

  // Counters for loss, fill run and telegram position.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ul_pkg::UL_ST_IDLE;
      lossCnt_reg <= '0;
      fillCnt_reg <= '0;
      telIdx_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (locked_reg || state_reg == ul_pkg::UL_ST_IDLE) begin
        lossCnt_reg <= '0;
      end else if (bitTick && !lossHit) begin
        lossCnt_reg <= lossCnt_reg + 7'h01;
      end
      if (state_reg != ul_pkg::UL_ST_FILL) begin
        fillCnt_reg <= '0;
      end else if (bitTick) begin
        fillCnt_reg <= fillCnt_reg + 7'h01;
      end
      if (state_reg != ul_pkg::UL_ST_FALLBACK) begin
        telIdx_reg <= '0;
      end else if (bitTick) begin
        telIdx_reg <= telLast ? 9'h000 : telIdx_reg + 9'h001;
      end
    end
  end

  // Output bits: live bits pass unchanged and in order; fill is all ones,
  // then the stored telegram repeats.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      airBit_reg <= 1'b0;
      airStrobe_reg <= 1'b0;
      fallback_reg <= 1'b0;
    end else begin
      airStrobe_reg <= 1'b0;
      fallback_reg <= (state_next == ul_pkg::UL_ST_FILL) ||
                      (state_next == ul_pkg::UL_ST_FALLBACK);
      case (state_reg)
        ul_pkg::UL_ST_LIVE: begin
          airBit_reg <= decBit_reg;
          airStrobe_reg <= decStrobe_reg && locked_reg;
        end
        ul_pkg::UL_ST_FILL: begin
          airBit_reg <= 1'b1;
          airStrobe_reg <= bitTick;
        end
        ul_pkg::UL_ST_FALLBACK: begin
          airBit_reg <= FALLBACK_TELEGRAM[telIdx_reg];
          airStrobe_reg <= bitTick;
        end
        default: begin
          airBit_reg <= airBit_reg;
        end
      endcase
    end
  end

  assign airBit = airBit_reg;
  assign airStrobe = airStrobe_reg;
  assign fallbackActive = fallback_reg;
  assign inputLocked = locked_reg;

endmodule

`default_nettype wire

// ---- dv/ul_link_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****************
// Line checker
// ****************
module ul_link_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Line and transponder status
  input wire logic lineP,
  input wire logic lineN,
  input wire logic energised,
  input wire logic airStrobe,
  input wire logic fallbackActive,
  input wire logic inputLocked
);
  // 341 bit periods in clock cycles, rounded up.
  localparam int LossLimit = 15103;
  logic lastP_reg;
  logic seenEdge_reg;
  logic [5:0] gapCnt_reg;
  logic [13:0] waitCnt_reg;
  wire lineEdge = lineP != lastP_reg;
  wire waiting = energised && !inputLocked && !fallbackActive;
  wire [5:0] gapCnt_next = lineEdge ? 6'h00 : gapCnt_reg + 6'((gapCnt_reg != 6'h3F));
  wire [13:0] waitCnt_next = waiting ? waitCnt_reg + 14'h0001 : 14'h0000;

  // The gap counter saturates so a dead line cannot wrap back into the legal range.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lastP_reg <= 1'b0;
      seenEdge_reg <= 1'b0;
      gapCnt_reg <= 6'h00;
      waitCnt_reg <= 14'h0000;
    end else begin
      lastP_reg <= lineP;
      seenEdge_reg <= seenEdge_reg | lineEdge;
      gapCnt_reg <= gapCnt_next;
      waitCnt_reg <= waitCnt_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Edges are one or two half cells apart: 22 or 23 cycles each.
  property p_complement; lineN == !lineP; endproperty
  a_complement: assert property (p_complement) else $error("conductors not complementary");
  property p_cell_gap;
    lineEdge && seenEdge_reg |-> gapCnt_reg inside {21, 22, 43, 44, 45};
  endproperty
  a_cell_gap: assert property (p_cell_gap) else $error("line edge misplaced");
  property p_strobe_pulse; airStrobe |=> !airStrobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_lock_edges; inputLocked |-> gapCnt_reg < 6'd56; endproperty
  a_lock_edges: assert property (p_lock_edges) else $error("lock kept on dead line");
  property p_first_bit; $rose(inputLocked) && !fallbackActive |=> !airStrobe[*8]; endproperty
  a_first_bit: assert property (p_first_bit) else $error("bit right after lock");
  property p_loss_bound; waitCnt_reg < LossLimit; endproperty
  a_loss_bound: assert property (p_loss_bound) else $error("fallback too late");
  property p_fb_hold; fallbackActive && energised |=> fallbackActive; endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("fallback left early");
  property p_clear; !energised ##1 !energised |-> !fallbackActive && !inputLocked; endproperty
  a_clear: assert property (p_clear) else $error("state kept unpowered");
  property p_fb_rate;
    fallbackActive && airStrobe |-> ##[44:45] (airStrobe || !fallbackActive);
  endproperty
  a_fb_rate: assert property (p_fb_rate) else $error("fallback rate wrong");
endmodule

`default_nettype wire

// ---- dv/uplink_biphase_telegram_input_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ul_defines.svh"

// ****************
// Top of the bench
// ****************
module uplink_biphase_telegram_input_test;
  // Arbitrary stored telegram, bit 0 sent first.
  localparam logic [`UL_TEL_BITS-1:0] TEL_PATTERN = {{85{4'h6}}, 1'b1};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic energised = 1'b0;
  logic [7:0] wordData = 8'h00;
  logic wordValid = 1'b0;
  logic wordReady;
  logic idleFill;
  logic cut = 1'b0;
  logic feed = 1'b0;
  logic noise_reg = 1'b0;
  wire [1:0] airBit;
  wire [1:0] airStrobe;
  wire [1:0] fb;
  wire [1:0] locked;
  logic q0[$];
  logic q1[$];
  logic sent[$];
  int fails = 0;
  int nCompared = 0;
  int wordCnt = 0;
  int i;
  int k;
  int hit;

  ul_link_if link();
  ul_link_if linkSw();
  // The second line is the first with its conductors swapped, or noise when cut.
  assign linkSw.lineP = cut ? noise_reg : link.lineN;
  assign linkSw.lineN = cut ? !noise_reg : link.lineP;

  ul_encoder_end i_ul_encoder_end (.clk_sys(clk_sys), .rst(rst), .link(link),
    .wordData(wordData), .wordValid(wordValid), .wordReady(wordReady), .idleFill(idleFill));
  ul_transponder_end #(.FALLBACK_TELEGRAM(TEL_PATTERN)) i_ul_transponder_end (
    .clk_sys(clk_sys), .rst(rst), .link(link), .energised(energised), .airBit(airBit[0]),
    .airStrobe(airStrobe[0]), .fallbackActive(fb[0]), .inputLocked(locked[0]));
  ul_transponder_end #(.FALLBACK_TELEGRAM(TEL_PATTERN)) i_ul_transponder_end_swap (
    .clk_sys(clk_sys), .rst(rst), .link(linkSw), .energised(energised), .airBit(airBit[1]),
    .airStrobe(airStrobe[1]), .fallbackActive(fb[1]), .inputLocked(locked[1]));
  ul_link_asserts i_ul_link_asserts (.clk_sys(clk_sys), .rst(rst), .lineP(link.lineP),
    .lineN(link.lineN), .energised(energised), .airStrobe(airStrobe[0]),
    .fallbackActive(fb[0]), .inputLocked(locked[0]));

  always #20 clk_sys = !clk_sys;

  // Noise toggles every cycle, far too fast for any legal cell.
  always @(posedge clk_sys) begin
    noise_reg <= !noise_reg;
    if (airStrobe[0] === 1'b1) q0.push_back(airBit[0]);
    if (airStrobe[1] === 1'b1) q1.push_back(airBit[1]);
  end

  // Keeps the encoder's buffer full, so the word side stalls on a refused word.
  always begin
    @(posedge clk_sys);
    if (feed) send_word(8'(wordCnt * 29 + 90));
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic send_word(input logic [7:0] d);
    int b;
    #2;
    wordData = d;
    wordValid = 1'b1;
    do @(posedge clk_sys); while (wordReady !== 1'b1);
    for (b = 0; b < 8; b++) sent.push_back(d[b]);
    wordCnt++;
    #2;
    wordValid = 1'b0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Waits at most 341 bit periods, then checks the run of ones, one full pass of the telegram and four more bits.
  task automatic check_fb(ref logic q[$], input int n);
    int t;
    int j;
    logic expBit;
    t = 0;
    while (fb[n] !== 1'b1 && t < 15103) begin
      cyc(1);
      t++;
    end
    check(fb[n], 1, "no fallback in time");
    q.delete();
    while (q.size() < `UL_FILL_BITS + 345) cyc(1);
    for (j = 0; j < `UL_FILL_BITS + 345; j++) begin
      expBit = (j < `UL_FILL_BITS) ? 1'b1 : TEL_PATTERN[(j - `UL_FILL_BITS) % `UL_TEL_BITS];
      check(q[j], expBit, "fallback bit");
    end
  endtask

  task automatic final_report;
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: idle line, live data, line cut, return and new passage.
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    energised = 1'b1;
    check(idleFill, 1, "no filler ones");
    check_fb(q0, 0);
    energised = 1'b0;
    cyc(3);
    check({fb, locked}, 0, "state not cleared");
    q0.delete();
    q1.delete();
    feed = 1'b1;
    cyc(20);
    energised = 1'b1;
    while (q0.size() < 320) cyc(1);
    check({idleFill, fb, locked}, 3, "not live");
    check(wordReady, 0, "buffer not kept full");
    hit = 0;
    for (i = 0; i + 128 <= q0.size(); i++) begin
      for (k = 0; k < 128 && q0[i + k] === sent[64 + k]; k++) begin
      end
      if (k == 128) hit = 1;
    end
    check(hit, 1, "stream order");
    check(q1.size(), q0.size(), "swap count");
    for (i = 0; i < q0.size() && i < q1.size(); i++) check(q1[i], q0[i], "swap bit");
    cut = 1'b1;
    check_fb(q1, 1);
    cut = 1'b0;
    cyc(3000);
    check(fb, 2, "fallback left");
    energised = 1'b0;
    cyc(3);
    energised = 1'b1;
    cyc(4000);
    check({fb[1], locked[1]}, 1, "no new decision");
    final_report;
  end

  // About a third more than the sequence needs.
  initial begin
    #3600000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report;
  end
endmodule

`default_nettype wire
